// ===== hw/brc_pkg.sv
// Purpose: Constants for the burst read control block
// Assumes: AHB-Lite register access, 16-bit host data
// Notes:   Summary of operation
// Summary of operation
// - Burst enable clear: host clock ignored, no burst read cycles served.
// - Burst enable set: host clock used, every read is a burst read.
// - Edge select clear: chip select and output enable sampled on rising clock.
// - Edge select set: sampled on falling clock, half clock extra delay.
// - Each word held one clock, or two clocks with data stretch set.
// - First word appears two plus latency field clocks after sampled selection.
// - With stretch, first word valid on latency clock and the next one.
// - Stretch off: burst carries two to the length field items.
// - Stretch on: burst carries two to length minus one items, one item at length zero.
// - Item is byte or word, chosen by interface width setting.
package brc_pkg;
    localparam logic [15:0] BRC_CFG_OFFSET = 16'h101C;
    localparam logic [15:0] BRC_CFG_RESET  = 16'h0000;
    localparam logic [15:0] BRC_CFG_WMASK  = 16'hFF07;
    localparam int          BRC_EN_BIT     = 0;
    localparam int          BRC_EDGE_BIT   = 1;
    localparam int          BRC_HOLD_BIT   = 2;
    localparam int          BRC_LAT_LSB    = 8;
    localparam int          BRC_LEN_LSB    = 12;
    localparam logic [3:0]  BRC_LAT_BASE   = 4'h2;
    localparam logic [3:0]  BRC_LEN_MAX    = 4'hA;
    // Width select register, offset of own choosing
    localparam logic [15:0] BRC_IFW_OFFSET = 16'h1020;
    localparam logic [15:0] BRC_STS_OFFSET = 16'h1024;
    typedef enum logic [1:0] {
        BRC_IDLE = 2'b00,
        BRC_WAIT = 2'b01,
        BRC_DATA = 2'b11,
        BRC_DONE = 2'b10
    } brc_state_t;
endpackage

// ===== hw/brc_fifo.sv
// Purpose: Word FIFO between data source and host port
// Assumes: Single clock
// Notes:   Full and empty are exact
`timescale 1ns/1ps
`default_nettype none
module brc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    // Pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : gParamCheck
        $error("DEPTH must be a power of two of at least 2, WIDTH at least 1");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_r;
    logic [AW:0]      rdPtr_r;
    logic             doWr;
    logic             doRd;
    assign inReady  = (wrPtr_r - rdPtr_r) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_r != rdPtr_r;
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;
    assign outData  = mem[rdPtr_r[AW-1:0]];
    always_ff @(posedge clock) begin
        if (doWr) begin
            mem[wrPtr_r[AW-1:0]] <= inData;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else if (flush) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else begin
            if (doWr) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (doRd) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== hw/brc_top.sv
// Purpose: Burst read control on the parallel host port
// Assumes: Host clock well below half of clock; pins sampled in three stages
// Notes:   Source feeds words through the FIFO; host sees them on hostData
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module brc_top #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hsel,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        hostClk,
    input  wire logic        chipSelect_n,
    input  wire logic        outputEnable_n,
    output logic      [15:0] hostData,
    output logic             hostDataOe_n,
    input  wire logic [15:0] srcData,
    input  wire logic        srcValid,
    output logic             srcReady,
    output logic             burstActive
);
    logic [15:0]        cfg_r;
    logic               wideIf_r;
    logic [2:0]         clkSync_r;
    logic [2:0]         csSync_r;
    logic [2:0]         oeSync_r;
    logic               clkLvl_r;
    logic               csLvl_r;
    logic               oeLvl_r;
    logic               rise;
    logic               fall;
    logic               sampleEdge;
    logic               burstEn;
    logic               hold;
    logic [3:0]         lat;
    logic [3:0]         len;
    logic [11:0]        items;
    brc_pkg::brc_state_t state_r;
    logic [4:0]         latCnt_r;
    logic [11:0]        itemCnt_r;
    logic               holdPh_r;
    logic               bytePh_r;
    logic [15:0]        fData;
    logic               fValid;
    logic               fReady;
    logic               flush;
    logic               advance;
    logic               selected;
    logic               dPhase_r;
    logic               dWrite_r;
    logic [15:0]        dAddr_r;
    logic [31:0]        rdMux;
    logic               rdDone_r;
    logic               enPrev_r;
    logic               live;
    logic               step;
    logic               load;
    logic [7:0]         lowByte_r;

    // AHB slave: one wait state on reads so hrdata comes from a flop; always OKAY
    assign hreadyout = !(dPhase_r && !dWrite_r && !rdDone_r);
    assign hresp     = 1'b0;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdDone_r <= 1'b0;
        end else begin
            rdDone_r <= dPhase_r && !dWrite_r && !rdDone_r;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dPhase_r <= 1'b0;
            dWrite_r <= 1'b0;
            dAddr_r  <= 16'h0000;
        end else if (hready) begin
            dPhase_r <= hsel && htrans[1];
            dWrite_r <= hwrite;
            dAddr_r  <= haddr[15:0];
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r    <= brc_pkg::BRC_CFG_RESET;
            wideIf_r <= 1'b1;
        end else if (dPhase_r && dWrite_r) begin
            if (dAddr_r == brc_pkg::BRC_CFG_OFFSET) begin
                cfg_r <= hwdata[15:0] & brc_pkg::BRC_CFG_WMASK;
            end
            if (dAddr_r == brc_pkg::BRC_IFW_OFFSET) begin
                wideIf_r <= hwdata[0];
            end
        end
    end
    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (dAddr_r)
            brc_pkg::BRC_CFG_OFFSET: rdMux = {16'h0000, cfg_r};
            brc_pkg::BRC_IFW_OFFSET: rdMux = {31'h0, wideIf_r};
            brc_pkg::BRC_STS_OFFSET: rdMux = {18'h0, itemCnt_r, state_r};
            default:                 rdMux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (dPhase_r && !dWrite_r && !rdDone_r) begin
            hrdata <= rdMux;
        end
    end
    // Stands until the next read, so the master takes it at the edge after the wait state

    assign burstEn = cfg_r[brc_pkg::BRC_EN_BIT];
    assign hold    = cfg_r[brc_pkg::BRC_HOLD_BIT];
    assign lat     = cfg_r[brc_pkg::BRC_LAT_LSB +: 4];
    // Oversized length clamped; software must keep it in range
    assign len     = (cfg_r[brc_pkg::BRC_LEN_LSB +: 4] > brc_pkg::BRC_LEN_MAX)
                     ? brc_pkg::BRC_LEN_MAX : cfg_r[brc_pkg::BRC_LEN_LSB +: 4];
    always_comb begin
        if (hold) begin
            items = (len == 4'h0) ? 12'h001 : 12'(12'h001 << (len - 4'h1));
        end else begin
            items = 12'(12'h001 << len);
        end
    end

    // Pin synchronisers; third and second stages must agree
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clkSync_r <= 3'h0;
            csSync_r  <= 3'h7;
            oeSync_r  <= 3'h7;
        end else begin
            clkSync_r <= {clkSync_r[1:0], hostClk && burstEn};
            csSync_r  <= {csSync_r[1:0], chipSelect_n};
            oeSync_r  <= {oeSync_r[1:0], outputEnable_n};
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clkLvl_r <= 1'b0;
            csLvl_r  <= 1'b1;
            oeLvl_r  <= 1'b1;
        end else begin
            if (clkSync_r[2] == clkSync_r[1]) begin
                clkLvl_r <= clkSync_r[2];
            end
            if (csSync_r[2] == csSync_r[1]) begin
                csLvl_r <= csSync_r[2];
            end
            if (oeSync_r[2] == oeSync_r[1]) begin
                oeLvl_r <= oeSync_r[2];
            end
        end
    end
    assign rise = (clkSync_r[2] == clkSync_r[1]) && clkSync_r[2] && !clkLvl_r;
    assign fall = (clkSync_r[2] == clkSync_r[1]) && !clkSync_r[2] && clkLvl_r;
    assign sampleEdge = cfg_r[brc_pkg::BRC_EDGE_BIT] ? fall : rise;
    assign selected   = !csLvl_r && !oeLvl_r;

    // Data always moves on the sampling edge, so falling mode lags half a clock
    assign live    = burstEn && selected;
    assign step    = live && sampleEdge && state_r == brc_pkg::BRC_DATA && (!hold || holdPh_r);
    assign load    = (live && sampleEdge && state_r == brc_pkg::BRC_WAIT && latCnt_r <= 5'h01)
                     || (step && itemCnt_r != 12'h001);
    // A word leaves the FIFO as it goes onto the bus; its low byte waits in a flop
    assign advance = load && (wideIf_r || !bytePh_r);
    assign fReady  = advance && fValid;
    // Words staged while disabled are kept; only switching off discards them
    assign flush   = enPrev_r && !burstEn;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            enPrev_r <= 1'b0;
        end else begin
            enPrev_r <= burstEn;
        end
    end

    brc_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock    (clock),
        .rst_n    (rst_n),
        .flush    (flush),
        .inData   (srcData),
        .inValid  (srcValid),
        .inReady  (srcReady),
        .outData  (fData),
        .outValid (fValid),
        .outReady (fReady)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= brc_pkg::BRC_IDLE;
            latCnt_r  <= 5'h00;
            itemCnt_r <= 12'h000;
            holdPh_r  <= 1'b0;
            bytePh_r  <= 1'b0;
        end else if (!burstEn || !selected) begin
            state_r   <= brc_pkg::BRC_IDLE;
            itemCnt_r <= 12'h000;
            holdPh_r  <= 1'b0;
            bytePh_r  <= 1'b0;
        end else if (sampleEdge) begin
            unique case (state_r)
                brc_pkg::BRC_IDLE: begin
                    state_r  <= brc_pkg::BRC_WAIT;
                    latCnt_r <= 5'(brc_pkg::BRC_LAT_BASE) + 5'(lat) - 5'h01;
                end
                brc_pkg::BRC_WAIT: begin
                    if (latCnt_r <= 5'h01) begin
                        state_r   <= brc_pkg::BRC_DATA;
                        itemCnt_r <= items;
                        bytePh_r  <= !wideIf_r;
                    end else begin
                        latCnt_r <= latCnt_r - 5'h01;
                    end
                end
                brc_pkg::BRC_DATA: begin
                    if (hold) begin
                        holdPh_r <= !holdPh_r;
                    end
                    if (!hold || holdPh_r) begin
                        bytePh_r  <= !wideIf_r && !bytePh_r;
                        itemCnt_r <= itemCnt_r - 12'h001;
                        if (itemCnt_r == 12'h001) begin
                            state_r <= brc_pkg::BRC_DONE;
                        end
                    end
                end
                brc_pkg::BRC_DONE: begin
                    state_r <= brc_pkg::BRC_DONE;
                end
            endcase
        end
    end

    // Output register: loaded once per item, high byte first in byte mode
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hostData  <= 16'h0000;
            lowByte_r <= 8'h00;
        end else if (load) begin
            if (wideIf_r) begin
                hostData <= fData;
            end else if (!bytePh_r) begin
                hostData  <= {8'h00, fData[15:8]};
                lowByte_r <= fData[7:0];
            end else begin
                hostData <= {8'h00, lowByte_r};
            end
        end
    end
    assign hostDataOe_n = !(state_r == brc_pkg::BRC_DATA);
    assign burstActive  = state_r != brc_pkg::BRC_IDLE;
endmodule
`default_nettype wire

// ===== bench/brc_properties.sv
// Purpose: Port checks for brc_top
// Assumes: Config changes only through AHB writes
// Notes:   Link pins pass sync stages, so bounds are loose
`timescale 1ns/1ps
`default_nettype none
module brc_properties (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hsel,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hostClk,
    input wire logic        chipSelect_n,
    input wire logic        outputEnable_n,
    input wire logic [15:0] hostData,
    input wire logic        hostDataOe_n,
    input wire logic        burstActive
);
    logic        wrPend_r;
    logic [15:0] cfg_r;
    // Shadow of the config word, stored at the data-phase edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_r <= 1'b0;
            cfg_r    <= 16'h0000;
        end else begin
            wrPend_r <= hsel && hready && htrans[1] && hwrite && haddr == {16'h0000, brc_pkg::BRC_CFG_OFFSET};
            if (wrPend_r)
                cfg_r <= hwdata[15:0] & brc_pkg::BRC_CFG_WMASK;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence cfgRead;
        hsel && hready && htrans[1] && !hwrite && haddr == {16'h0000, brc_pkg::BRC_CFG_OFFSET};
    endsequence
    sequence quietClk;
        $stable(hostClk) [*8];
    endsequence
    AST_DISABLED_IDLE: assert property (!cfg_r[0] [*8] |-> !burstActive && hostDataOe_n)
        else $error("burst while disabled");
    AST_DRIVE_IN_BURST: assert property (!hostDataOe_n |-> burstActive)
        else $error("data driven outside burst");
    AST_CS_RELEASE: assert property (chipSelect_n [*8] |-> hostDataOe_n)
        else $error("driving while deselected");
    AST_OE_RELEASE: assert property (outputEnable_n [*8] |-> hostDataOe_n)
        else $error("driving without output enable");
    AST_WORD_HOLD: assert property (quietClk |-> $stable(hostData))
        else $error("word changed without host clock");
    AST_SELECT_FIRST: assert property ($fell(hostDataOe_n) |-> !$past(chipSelect_n, 2))
        else $error("data before selection");
    AST_RSV_ZERO: assert property (cfgRead |-> ##2 hrdata[7:3] == 5'h00)
        else $error("reserved bits not zero");
    AST_CFG_READBACK: assert property (cfgRead |-> ##2 hrdata[15:0] == cfg_r)
        else $error("config readback wrong");
endmodule
`default_nettype wire

// ===== bench/brc_host_model.sv
// Purpose: Host side of the burst port
// Assumes: Host clock idles low between frames
// Notes:   Each word is latched one host clock after it leaves
`timescale 1ns/1ps
`default_nettype none
module brc_host_model (
    output logic             hostClk,
    output logic             chipSelect_n,
    output logic             outputEnable_n,
    input  wire logic [15:0] hostData,
    input  wire logic        hostDataOe_n
);
    logic        drv [64];
    logic [15:0] dat [64];
    int          n;
    initial begin
        hostClk = 1'b0;
        chipSelect_n = 1'b1;
        outputEnable_n = 1'b1;
        n = 0;
    end
    task automatic grab;
        drv[n] = !hostDataOe_n;
        dat[n] = hostData;
        n++;
    endtask
    // One frame is one burst read; stall pauses the clock mid-frame
    task automatic frame(input int edges, input logic fall, input int stall);
        n = 0;
        #130;
        chipSelect_n = 1'b0;
        outputEnable_n = 1'b0;
        for (int i = 0; i < edges; i++) begin
            #200 hostClk = 1'b1;
            if (!fall) grab();
            #200 hostClk = 1'b0;
            if (fall) grab();
            if (i == stall) #1600;
        end
        #100;
        chipSelect_n = 1'b1;
        outputEnable_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for brc_top
// Assumes: Host model drives the link pins
// Notes:   Every enabled burst consumes all queued source words; a disabled one leaves them queued
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [31:0] CFG = {16'h0000, brc_pkg::BRC_CFG_OFFSET};
    logic        clock, rst_n, hwrite, hsel, hreadyout, hresp, hostClk, chipSelect_n, outputEnable_n;
    logic        hostDataOe_n, srcValid, srcReady, burstActive;
    logic [31:0] haddr, hwdata, hrdata, dummy;
    logic [15:0] hostData, srcData, seqW;
    logic [2:0]  hsize;
    logic [1:0]  htrans;
    logic [15:0] srcQ [$];
    int          errorCnt = 0;
    int          totalChecks = 0;
    brc_top dut (.clock(clock), .rst_n(rst_n), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .hostClk(hostClk), .chipSelect_n(chipSelect_n), .outputEnable_n(outputEnable_n), .hostData(hostData),
        .hostDataOe_n(hostDataOe_n), .srcData(srcData), .srcValid(srcValid), .srcReady(srcReady),
        .burstActive(burstActive));
    brc_host_model host (.hostClk(hostClk), .chipSelect_n(chipSelect_n), .outputEnable_n(outputEnable_n),
        .hostData(hostData), .hostDataOe_n(hostDataOe_n));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic closeOut;
        $display("checks %0d errors %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Read data is taken at the edge that ends the data phase
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clock);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic fill(input int cnt);
        logic rdy;
        @(posedge clock);
        for (int i = 0; i < cnt; i++) begin
            srcData <= seqW;
            srcValid <= 1'b1;
            do begin
                #1 rdy = srcReady;
                @(posedge clock);
            end while (!rdy);
            srcQ.push_back(seqW);
            seqW++;
        end
        srcValid <= 1'b0;
        #1;
    endtask
    task automatic burst(input logic [15:0] cfg, input int edges, input int hold, input int items);
        int fi;
        int k;
        fi = -1;
        k = 0;
        bus(1'b1, CFG, {16'h0000, cfg}, dummy);
        host.frame(edges, cfg[1], 3);
        for (int i = 0; i < host.n; i++) begin
            if (host.drv[i]) begin
                if (fi < 0) fi = i;
                if (k < items * hold) check(host.dat[i], srcQ[k / hold]);
                k++;
            end
        end
        check(k, items * hold);
        if (items > 0) check(fi, cfg[11:8] + 2);
        if (items > 0) srcQ.delete();
    endtask
    task automatic regScenario;
        bus(1'b0, CFG, 32'h0, dummy);
        check(dummy, 32'h0000_0000);
        bus(1'b0, {16'h0000, brc_pkg::BRC_IFW_OFFSET}, 32'h0, dummy);
        check(dummy, 32'h0000_0001);
        bus(1'b1, CFG, 32'h0000_A0FF, dummy);
        bus(1'b0, CFG, 32'h0, dummy);
        check(dummy, 32'h0000_A007);
        bus(1'b0, 32'h0000_1100, 32'h0, dummy);
        check(dummy, 32'h0000_0000);
        bus(1'b1, CFG, 32'h0, dummy);
    endtask
    // Full FIFO must stay full while bursts are off
    task automatic disabledScenario;
        fill(8);
        check(srcReady, 1'b0);
        burst(16'h3100, 12, 1, 0);
        check(srcReady, 1'b0);
    endtask
    task automatic riseScenario;
        burst(16'h3101, 16, 1, 8);
        #1 check(srcReady, 1'b1);
    endtask
    task automatic fallHoldScenario;
        fill(2);
        burst(16'h2007, 12, 2, 2);
    endtask
    // Byte mode: one word goes out as high byte, then low byte
    task automatic byteScenario;
        logic [15:0] w;
        bus(1'b1, {16'h0000, brc_pkg::BRC_IFW_OFFSET}, 32'h0, dummy);
        fill(1);
        w = srcQ[0];
        srcQ.delete();
        srcQ.push_back({8'h00, w[15:8]});
        srcQ.push_back({8'h00, w[7:0]});
        burst(16'h1001, 8, 1, 2);
        bus(1'b1, {16'h0000, brc_pkg::BRC_IFW_OFFSET}, 32'h1, dummy);
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        #200000;
        errorCnt++;
        closeOut();
    end
    initial begin
        rst_n = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        hsel = 1'b1;
        srcData = 16'h0;
        srcValid = 1'b0;
        seqW = 16'hC3A0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        regScenario();
        disabledScenario();
        riseScenario();
        fallHoldScenario();
        byteScenario();
        closeOut();
    end
endmodule
bind brc_top brc_properties chk (.clock(clock), .rst_n(rst_n), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hsel(hsel), .hready(hready), .hrdata(hrdata), .hostClk(hostClk), .chipSelect_n(chipSelect_n),
    .outputEnable_n(outputEnable_n), .hostData(hostData), .hostDataOe_n(hostDataOe_n), .burstActive(burstActive));
`default_nettype wire
